// [bench/gpio_line_model.sv]
`timescale 1ns/1ps

// ********
// External side of the lines
// ********
// Any low driver wins and an undriven line floats high on its pull-up,
// so an open-drain release can never read back as a stale level.
module gpio_line_model (
    input  wire logic [31:0] dev_out,
    input  wire logic [31:0] dev_oe,
    input  wire logic [31:0] ext_val,
    input  wire logic [31:0] ext_oe,
    output wire logic [31:0] line
);
    assign line = ~(dev_oe & ~dev_out) & ~(ext_oe & ~ext_val);
endmodule

// [bench/gpio_sync_output_input_filter_bench.sv]
`timescale 1ns/1ps

module gpio_sync_output_input_filter_bench;
    logic                 clk          = 1'b0;
    logic                 arst_n       = 1'b0;
    logic                 clk_on       = 1'b1;
    logic                 rd           = 1'b0;
    gpio_pkg::reg_wr_t    wr [11]      = '{default: '0};
    gpio_pkg::drive_sel_t dsel         = '0;
    logic [31:0]          ext_oe       = '0;
    logic [31:0]          ext_val      = '0;
    wire  [31:0]          pin_in;
    logic [31:0]          pout, poe, per, ods, wms, odst, fst, imsk, ist, pls;
    logic                 irq;
    int                   fails        = 0;
    int                   total_checks = 0;
    // Rows: port index, written bits, expected target register afterwards
    int                   row_k [13]   = '{2, 3, 2, 4, 2, 0, 1, 5, 6, 7, 8, 9, 10};
    logic [31:0]          row_b [13]   = '{32'hffff_ffff, 32'hff, 32'h1234_5678, 32'hf, 32'h0,
        32'h8000_0001, 32'h9, 32'hf, 32'h3, 32'h300, 32'h100, 32'hffff_ffff, 32'hffff_0000};
    logic [31:0]          row_e [13]   = '{32'h0, 32'hff, 32'h78, 32'hf0, 32'h8, 32'h8000_0009,
        32'h8000_0000, 32'hf, 32'hc, 32'h300, 32'h200, 32'hffff_ffff, 32'hffff};

    always #4 clk = ~clk;

    gpio_sync_output_input_filter i_gpio_sync_output_input_filter (
        .clk, .arst_n, .clk_on, .set_output_reg(wr[0]), .clear_output_reg(wr[1]),
        .output_data_wr(wr[2]), .write_mask_enable(wr[3]), .write_mask_disable(wr[4]),
        .open_drain_enable(wr[5]), .open_drain_disable(wr[6]), .filter_enable(wr[7]),
        .filter_disable(wr[8]), .change_irq_enable(wr[9]), .change_irq_disable(wr[10]),
        .change_irq_status_rd(rd), .drive_sel(dsel), .pin_in, .pin_out(pout), .pin_oe(poe),
        .periph_in(per), .output_data_status(ods), .write_mask_status(wms),
        .open_drain_status(odst), .filter_status(fst), .change_irq_mask(imsk),
        .change_irq_status(ist), .pin_level_status(pls), .irq);

    gpio_line_model i_gpio_line_model (
        .dev_out(pout), .dev_oe(poe), .ext_val, .ext_oe, .line(pin_in));

    // ********
    // Helpers
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Strobe is held one full cycle, then two idle cycles let the target settle
    task automatic write(input int k, input logic [31:0] b);
        wr[k] = {1'b1, b};
        wait_cyc(1);
        wr[k] = '0;
        wait_cyc(2);
    endtask

    task automatic read_clear();
        wait_cyc(10);
        rd = 1'b1;
        wait_cyc(1);
        rd = 1'b0;
        wait_cyc(1);
    endtask

    function automatic logic [31:0] target(input int k);
        case (k)
            0, 1, 2: return ods;
            3, 4: return wms;
            5, 6: return odst;
            7, 8: return fst;
            default: return imsk;
        endcase
    endfunction

    task automatic complete_run();
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********
    // Sequence
    // ********
    initial begin
        wait_cyc(16);
        arst_n = 1'b1;
        wait_cyc(1);
        check(wms | odst | fst | imsk | ods, 32'h0);
        for (int i = 0; i < 13; i++) begin
            write(row_k[i], row_b[i]);
            check(target(row_k[i]), row_e[i]);
        end
        // Line 3 handed to a peripheral that drives high while open drain
        dsel = '{32'hffff_fff7, 32'hff, 32'h8, 32'h8};
        write(0, 32'h5);
        wait_cyc(10);
        check(poe & 32'hf, 32'h3);
        check(pout & poe & 32'hf, 32'h1);
        check(pls & 32'hf, 32'hd);
        check(per & 32'hf, 32'hd);
        read_clear();
        check(ist | {31'h0, irq}, 32'h0);
        // Two-cycle low pulse is long enough to pass on filtered line 9 and on line 8
        ext_oe[9:8] = 2'b11;
        wait_cyc(2);
        ext_oe[9:8] = 2'b00;
        wait_cyc(10);
        check(ist, 32'h300);
        check({31'h0, irq}, 32'h1);
        read_clear();
        ext_oe[20] = 1'b1;
        wait_cyc(10);
        check({ist[31:1], irq}, 32'h0010_0000);
        ext_oe[9] = 1'b1;
        wait_cyc(10);
        check({ist[31:1], irq}, 32'h0010_0201);
        read_clear();
        clk_on = 1'b0;
        ext_oe[20] = 1'b0;
        wait_cyc(10);
        check(pls & 32'h0010_0000, 32'h0);
        check(ist, 32'h0);
        clk_on = 1'b1;
        wait_cyc(10);
        check(pls & 32'h0010_0000, 32'h0010_0000);
        read_clear();
        // Line 8 change reaches the status on the fifth edge, the same edge as the read
        ext_oe[8] = 1'b1;
        wait_cyc(4);
        rd = 1'b1;
        wait_cyc(1);
        rd = 1'b0;
        check(ist, 32'h100);
        arst_n = 1'b0;
        wait_cyc(2);
        check(wms | odst | fst | imsk | ods | ist, 32'h0);
        arst_n = 1'b1;
        wait_cyc(2);
        complete_run();
    end

    // Whole sequence is well under 400 cycles
    initial begin
        #20000;
        fails++;
        complete_run();
    end
endmodule

// [bench/gpio_sync_output_input_filter_properties.sv]
`timescale 1ns/1ps

module gpio_sync_checker #(
    parameter int NUM_LINES = gpio_pkg::NUM_LINES
) (
    input wire logic                 clk,
    input wire logic                 arst_n,
    input wire logic                 clk_on,
    input wire gpio_pkg::reg_wr_t    set_output_reg,
    input wire gpio_pkg::reg_wr_t    clear_output_reg,
    input wire gpio_pkg::reg_wr_t    output_data_wr,
    input wire gpio_pkg::reg_wr_t    write_mask_enable,
    input wire gpio_pkg::reg_wr_t    write_mask_disable,
    input wire gpio_pkg::reg_wr_t    open_drain_enable,
    input wire gpio_pkg::reg_wr_t    open_drain_disable,
    input wire logic                 change_irq_status_rd,
    input wire logic [NUM_LINES-1:0] pin_out,
    input wire logic [NUM_LINES-1:0] pin_oe,
    input wire logic [NUM_LINES-1:0] output_data_status,
    input wire logic [NUM_LINES-1:0] write_mask_status,
    input wire logic [NUM_LINES-1:0] open_drain_status,
    input wire logic [NUM_LINES-1:0] change_irq_mask,
    input wire logic [NUM_LINES-1:0] change_irq_status,
    input wire logic [NUM_LINES-1:0] pin_level_status,
    input wire logic                 irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ********
    // Sequences
    // ********
    sequence s_gated;
        !clk_on ##1 !clk_on;
    endsequence
    sequence s_lone_direct;
        output_data_wr.stb && !set_output_reg.stb && !clear_output_reg.stb;
    endsequence

    // ********
    // Output side
    // ********
    AST_DIRECT_WR: assert property (s_lone_direct |=>
        output_data_status == (($past(output_data_wr.bits) & $past(write_mask_status))
        | ($past(output_data_status) & ~$past(write_mask_status))))
        else $error("direct write touched unmasked bits");
    AST_MASK_SET: assert property (write_mask_enable.stb && !write_mask_disable.stb |=>
        (write_mask_status & $past(write_mask_enable.bits)) == $past(write_mask_enable.bits))
        else $error("mask enable not applied");
    AST_MASK_CLR: assert property (write_mask_disable.stb |=>
        (write_mask_status & $past(write_mask_disable.bits)) == '0)
        else $error("mask disable not applied");
    AST_CLR_OUT: assert property (clear_output_reg.stb |=>
        (output_data_status & $past(clear_output_reg.bits)) == '0)
        else $error("clear output not applied");
    AST_OD_SET: assert property (open_drain_enable.stb && !open_drain_disable.stb |=>
        (open_drain_status & $past(open_drain_enable.bits)) == $past(open_drain_enable.bits))
        else $error("open drain enable not applied");
    AST_OD_NO_HIGH: assert property (
        (pin_oe & pin_out & $past(open_drain_status)) == '0)
        else $error("open drain line driven high");

    // ********
    // Input side
    // ********
    AST_FREEZE: assert property (s_gated |-> $stable(pin_level_status))
        else $error("readback moved with clock off");
    AST_CHANGE_SETS: assert property (
        (change_irq_status & (pin_level_status ^ $past(pin_level_status)))
        == (pin_level_status ^ $past(pin_level_status)))
        else $error("level change did not set status");
    AST_STICKY: assert property (!change_irq_status_rd |=>
        (change_irq_status & $past(change_irq_status)) == $past(change_irq_status))
        else $error("status lost without read");
    AST_RD_CLEAR: assert property (change_irq_status_rd |=>
        (change_irq_status & ~(pin_level_status ^ $past(pin_level_status))) == '0)
        else $error("read left old status");
    AST_IRQ_OR: assert property (irq == |(change_irq_status & change_irq_mask))
        else $error("irq not OR of masked status");
endmodule

bind gpio_sync_output_input_filter gpio_sync_checker #(.NUM_LINES(NUM_LINES)) i_gpio_sync_checker (
    .clk, .arst_n, .clk_on, .set_output_reg, .clear_output_reg, .output_data_wr,
    .write_mask_enable, .write_mask_disable, .open_drain_enable, .open_drain_disable,
    .change_irq_status_rd, .pin_out, .pin_oe, .output_data_status, .write_mask_status,
    .open_drain_status, .change_irq_mask, .change_irq_status, .pin_level_status, .irq
);

// [rtl/gpio_pkg.sv]
package gpio_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_LINES = 32;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [NUM_LINES-1:0] ALL_ZERO       = 32'h0000_0000;
    localparam logic [NUM_LINES-1:0] WMASK_RST      = 32'h0000_0000;
    localparam logic [NUM_LINES-1:0] OPEN_DRAIN_RST = 32'h0000_0000;
    localparam logic [NUM_LINES-1:0] FILTER_RST     = 32'h0000_0000;
    localparam logic [NUM_LINES-1:0] IRQ_MASK_RST   = 32'h0000_0000;
    localparam logic [NUM_LINES-1:0] IRQ_STAT_RST   = 32'h0000_0000;
    localparam logic [NUM_LINES-1:0] OUT_DATA_RST   = 32'h0000_0000;

    // ************************************************************
    // Carriers
    // ************************************************************
    // One write strobe with its 32 data bits, one bit per line
    typedef struct packed {
        logic                 stb;
        logic [NUM_LINES-1:0] bits;
    } reg_wr_t;

    // Drive request of one bank of lines from the output mux upstream
    typedef struct packed {
        logic [NUM_LINES-1:0] pio_ctrl;
        logic [NUM_LINES-1:0] pio_oe;
        logic [NUM_LINES-1:0] periph_out;
        logic [NUM_LINES-1:0] periph_oe;
    } drive_sel_t;

endpackage

// [rtl/gpio_sync_output_input_filter.sv]
// What this block does
// (R1) Direct output write touches only mask-enabled bits
// (R2) Mask enable/disable writes set/clear mask bits
// (R3) Write mask resets to zero
// (R4) Open-drain lines only pull low, else release
// (R5) Open-drain set/clear applies under any owner
// (R6) Open-drain status resets to zero
// (R7) Pin level readback shows real line level
// (R8) Readback freezes while controller clock is off
// (R9) Filter rejects half-cycle glitches, passes two-cycle pulses
// (R10) Filter adds two cycles of latency
// (R11) Filter enable/disable bits activate the filter
// (R12) Peripherals always see unfiltered pin level
// (R13) Filter runs only while controller clock runs
// (R14) Irq enable/disable set/clear readable mask bits
// (R15) Change found by comparing consecutive clocked samples
// (R16) Change detection works in every line configuration
// (R17) Change sets status; masked status raises interrupt
// (R18) All lines' masked conditions ORed to one output
// (R19) Status read clears all status bits at once
// (R20) Set/clear output writes ignore the write mask
// (R21) Registers 32 bits, one bit per line
// (R22) Pins synchronised before filter, detect, readback
// (R23) Change in read cycle survives the clear
`timescale 1ns/1ps

module gpio_sync_output_input_filter #(
    parameter int NUM_LINES = gpio_pkg::NUM_LINES
) (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic                     clk_on,
    input  wire gpio_pkg::reg_wr_t        set_output_reg,
    input  wire gpio_pkg::reg_wr_t        clear_output_reg,
    input  wire gpio_pkg::reg_wr_t        output_data_wr,
    input  wire gpio_pkg::reg_wr_t        write_mask_enable,
    input  wire gpio_pkg::reg_wr_t        write_mask_disable,
    input  wire gpio_pkg::reg_wr_t        open_drain_enable,
    input  wire gpio_pkg::reg_wr_t        open_drain_disable,
    input  wire gpio_pkg::reg_wr_t        filter_enable,
    input  wire gpio_pkg::reg_wr_t        filter_disable,
    input  wire gpio_pkg::reg_wr_t        change_irq_enable,
    input  wire gpio_pkg::reg_wr_t        change_irq_disable,
    input  wire logic                     change_irq_status_rd,
    input  wire gpio_pkg::drive_sel_t     drive_sel,
    input  wire logic [NUM_LINES-1:0]     pin_in,
    output logic      [NUM_LINES-1:0]     pin_out,
    output logic      [NUM_LINES-1:0]     pin_oe,
    output logic      [NUM_LINES-1:0]     periph_in,
    output logic      [NUM_LINES-1:0]     output_data_status,
    output logic      [NUM_LINES-1:0]     write_mask_status,
    output logic      [NUM_LINES-1:0]     open_drain_status,
    output logic      [NUM_LINES-1:0]     filter_status,
    output logic      [NUM_LINES-1:0]     change_irq_mask,
    output logic      [NUM_LINES-1:0]     change_irq_status,
    output logic      [NUM_LINES-1:0]     pin_level_status,
    output logic                          irq
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Set/clear pair on a status word; clear wins when both hit a bit
    function automatic logic [NUM_LINES-1:0] set_clear(
        input logic [NUM_LINES-1:0] cur,
        input gpio_pkg::reg_wr_t    set_wr,
        input gpio_pkg::reg_wr_t    clr_wr
    );
        logic [NUM_LINES-1:0] v;
        v = cur;
        if (set_wr.stb) begin
            v = v | set_wr.bits[NUM_LINES-1:0];
        end
        if (clr_wr.stb) begin
            v = v & ~clr_wr.bits[NUM_LINES-1:0];
        end
        return v;
    endfunction

    // ************************************************************
    // Signals
    // ************************************************************
    logic [NUM_LINES-1:0] level;
    logic [NUM_LINES-1:0] level_filt;
    logic [NUM_LINES-1:0] level_sel;
    logic [NUM_LINES-1:0] prev_r;
    logic [NUM_LINES-1:0] change;
    logic [NUM_LINES-1:0] odsr_nxt;
    logic [NUM_LINES-1:0] isr_nxt;
    logic [NUM_LINES-1:0] drv_data;
    logic [NUM_LINES-1:0] drv_en;

    // ************************************************************
    // Input capture
    // ************************************************************
    input_conditioner #(
        .WIDTH (NUM_LINES)
    ) u_cond (
        .clk        (clk),
        .arst_n     (arst_n),
        .clk_on     (clk_on),
        .pin_in     (pin_in),
        .level      (level),
        .level_filt (level_filt)
    ); // R22

    // Filtered level only where the filter bit is set
    assign level_sel = (filter_status & level_filt) | (~filter_status & level); // R11

    // ************************************************************
    // Configuration bits
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_mask_status <= gpio_pkg::WMASK_RST; // R3
        end else begin
            write_mask_status <= set_clear(write_mask_status,
                                           write_mask_enable,
                                           write_mask_disable); // R2
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            open_drain_status <= gpio_pkg::OPEN_DRAIN_RST; // R6
        end else begin
            open_drain_status <= set_clear(open_drain_status,
                                           open_drain_enable,
                                           open_drain_disable); // R5
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filter_status <= gpio_pkg::FILTER_RST;
        end else begin
            filter_status <= set_clear(filter_status,
                                       filter_enable,
                                       filter_disable); // R11
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            change_irq_mask <= gpio_pkg::IRQ_MASK_RST;
        end else begin
            change_irq_mask <= set_clear(change_irq_mask,
                                         change_irq_enable,
                                         change_irq_disable); // R14
        end
    end

    // ************************************************************
    // Output data
    // ************************************************************
    // Direct write lands first, then set and clear override it, so a
    // plain set or clear in the same cycle is never masked away
    always_comb begin
        odsr_nxt = output_data_status;
        if (output_data_wr.stb) begin
            odsr_nxt = (odsr_nxt & ~write_mask_status)
                     | (output_data_wr.bits[NUM_LINES-1:0] & write_mask_status); // R1
        end
        odsr_nxt = set_clear(odsr_nxt, set_output_reg, clear_output_reg); // R20
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_data_status <= gpio_pkg::OUT_DATA_RST;
        end else begin
            output_data_status <= odsr_nxt; // R21
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    // Owner picks data and enable; open drain turns a high into release
    generate
        for (genvar i = 0; i < NUM_LINES; i++) begin : g_drive
            assign drv_data[i] = drive_sel.pio_ctrl[i] ? output_data_status[i]
                                                       : drive_sel.periph_out[i];
            assign drv_en[i]   = drive_sel.pio_ctrl[i] ? drive_sel.pio_oe[i]
                                                       : drive_sel.periph_oe[i];
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= gpio_pkg::ALL_ZERO;
            pin_oe  <= gpio_pkg::ALL_ZERO;
        end else begin
            pin_out <= drv_data & ~open_drain_status; // R4
            pin_oe  <= drv_en & ~(open_drain_status & drv_data); // R4 R5
        end
    end

    // Peripherals bypass the filter and the clock freeze
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_in <= gpio_pkg::ALL_ZERO;
        end else begin
            periph_in <= level; // R12
        end
    end

    // ************************************************************
    // Pin level readback
    // ************************************************************
    // Holds the last sampled levels while the controller clock is off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_level_status <= gpio_pkg::ALL_ZERO;
        end else if (clk_on) begin // R8
            pin_level_status <= level_sel; // R7 R12
        end
    end

    // ************************************************************
    // Change detection
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= gpio_pkg::ALL_ZERO;
        end else if (clk_on) begin
            prev_r <= level_sel; // R15
        end
    end

    // Independent of owner and output enable: every line is watched
    assign change = clk_on ? (level_sel ^ prev_r) : gpio_pkg::ALL_ZERO; // R15 R16

    // A read clears everything seen so far, but a change in that same
    // cycle is kept so no edge is lost
    always_comb begin
        isr_nxt = change_irq_status_rd ? gpio_pkg::ALL_ZERO : change_irq_status; // R19
        isr_nxt = isr_nxt | change; // R17 R23
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            change_irq_status <= gpio_pkg::IRQ_STAT_RST;
        end else begin
            change_irq_status <= isr_nxt;
        end
    end

    // ************************************************************
    // Interrupt output
    // ************************************************************
    // Built from next-state so irq tracks the status register exactly
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(isr_nxt & set_clear(change_irq_mask,
                                         change_irq_enable,
                                         change_irq_disable)); // R17 R18
        end
    end

endmodule

// [rtl/input_conditioner.sv]
`timescale 1ns/1ps

module input_conditioner #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             clk_on,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] level_filt
);

    // ************************************************************
    // Three-stage capture of the asynchronous pins
    // ************************************************************
    logic [WIDTH-1:0] sync1_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] sync3_r;
    logic [WIDTH-1:0] hist_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // ************************************************************
    // Settled level and glitch-filtered level
    // ************************************************************
    // A change counts once stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    level[i] <= sync3_r[i];
                end
            end
        end
    end

    // Filter needs one more agreeing sample, so short pulses die here;
    // it freezes with the controller clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist_r     <= '0;
            level_filt <= '0;
        end else if (clk_on) begin // R13
            hist_r <= level;
            for (int i = 0; i < WIDTH; i++) begin
                if (hist_r[i] == level[i]) begin // R9 R10
                    level_filt[i] <= level[i];
                end
            end
        end
    end

endmodule
